/* hw/intc_pkg.sv */
// constants of the prioritized interrupt controller
// assumes an 8-bit register port with a 16-bit byte address
package intc_pkg;

	// register byte addresses
	localparam logic [15:0] ADDR_EDGE_SEL  = 16'hFFF2;
	localparam logic [15:0] ADDR_ENABLE_1  = 16'hFFF3;
	localparam logic [15:0] ADDR_ENABLE_2  = 16'hFFF4;
	localparam logic [15:0] ADDR_REQUEST_1 = 16'hFFF6;
	localparam logic [15:0] ADDR_REQUEST_2 = 16'hFFF7;
	localparam logic [15:0] ADDR_WAKEUP    = 16'hFFF9;

	// reset values
	localparam logic [7:0] RST_EDGE_SEL  = 8'hE0;
	localparam logic [7:0] RST_ENABLE_1  = 8'h00;
	localparam logic [7:0] RST_ENABLE_2  = 8'h00;
	localparam logic [7:0] RST_REQUEST_1 = 8'h20;
	localparam logic [7:0] RST_REQUEST_2 = 8'h00;
	localparam logic [7:0] RST_WAKEUP    = 8'h00;

	// fixed bits: edge select 7..5 and request one bit 5 read as one
	localparam logic [7:0] EDGE_SEL_FIXED  = 8'hE0;
	localparam logic [7:0] REQUEST_1_FIXED = 8'h20;

	// source counts
	localparam int EXT_PINS    = 5;
	localparam int WAKE_PINS   = 8;
	localparam int INT_SOURCES = 20;

	// field positions, enable one and request one
	localparam int BIT_TIMER_A = 7;
	localparam int BIT_SERIAL1 = 6;
	localparam int BIT_WAKEUP  = 5;
	// field positions, enable two and request two
	localparam int BIT_DIRECT  = 7;
	localparam int BIT_ADC     = 6;
	localparam int BIT_SERIAL2 = 5;
	localparam int BIT_TIMER_G = 4;
	localparam int BIT_HIGH_TM = 3;
	localparam int BIT_LOW_TM  = 2;
	localparam int BIT_TIMER_C = 1;
	localparam int BIT_TIMER_B = 0;

	// vector numbers
	localparam int VEC_W = 5;
	localparam logic [VEC_W-1:0] VEC_RESET   = 5'h00;
	localparam logic [VEC_W-1:0] VEC_PIN0    = 5'h04;
	localparam logic [VEC_W-1:0] VEC_WAKEUP  = 5'h09;
	localparam logic [VEC_W-1:0] VEC_SERIAL1 = 5'h0A;
	localparam logic [VEC_W-1:0] VEC_TIMER_A = 5'h0B;
	localparam logic [VEC_W-1:0] VEC_TIMER_B = 5'h0C;
	localparam logic [VEC_W-1:0] VEC_TIMER_C = 5'h0D;
	localparam logic [VEC_W-1:0] VEC_LOW_TM  = 5'h0E;
	localparam logic [VEC_W-1:0] VEC_HIGH_TM = 5'h0F;
	localparam logic [VEC_W-1:0] VEC_TIMER_G = 5'h10;
	localparam logic [VEC_W-1:0] VEC_SERIAL2 = 5'h11;
	localparam logic [VEC_W-1:0] VEC_SERIAL3 = 5'h12;
	localparam logic [VEC_W-1:0] VEC_ADC     = 5'h13;
	localparam logic [VEC_W-1:0] VEC_DIRECT  = 5'h14;
	localparam int VEC_LAST = 20;

	// exception sequencing
	typedef enum logic [1:0] {
		ST_RESET  = 2'b00,
		ST_IDLE   = 2'b01,
		ST_HANDLE = 2'b11
	} exc_state_e;

endpackage

/* hw/pin_edge_sync.sv */
// two-stage synchroniser and selectable edge detector for pin inputs
// assumes pins are asynchronous to core_clk
module pin_edge_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] pin,
	input  wire logic [WIDTH-1:0] rise_sel,
	output logic      [WIDTH-1:0] edge_pulse
);
	if (WIDTH < 1) begin : g_width_check
		$error("pin_edge_sync: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] prev_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '1;
			sync_r <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			// one pulse per qualifying edge
			assign edge_pulse[i] = rise_sel[i] ?
				(sync_r[i] & ~prev_r[i]) : (~sync_r[i] & prev_r[i]);
		end
	endgenerate
endmodule // pin_edge_sync

/* hw/prioritized_interrupt_controller.sv */
// prioritized interrupt controller: flags, enables, arbitration, vectors
// assumes a cpu core on core_clk and peripherals giving event pulses
module prioritized_interrupt_controller (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// external pins
	input  wire logic [4:0]  ext_request_pin,
	input  wire logic [7:0]  wakeup_pin,
	// internal event pulses
	input  wire logic        serial1_done,
	input  wire logic        timer_a_ovf,
	input  wire logic        timer_b_ovf,
	input  wire logic        timer_c_ovf,
	input  wire logic        low_timer_match,
	input  wire logic        low_timer_ovf,
	input  wire logic        high_timer_match,
	input  wire logic        high_timer_ovf,
	input  wire logic        timer_g_capture,
	input  wire logic        timer_g_ovf,
	input  wire logic        serial2_done,
	input  wire logic        serial2_abort,
	input  wire logic [5:0]  serial3_req,
	input  wire logic        adc_done,
	input  wire logic        direct_transfer,
	// cpu side
	input  wire logic        cpu_mask_bit,
	input  wire logic        instr_boundary,
	input  wire logic        exc_done,
	output logic             int_pending,
	output logic             exc_start,
	output logic      [4:0]  vector_num,
	output logic      [15:0] vector_addr
);
	// registers
	logic [7:0]  edge_sel_r;
	logic [7:0]  edge_sel_nxt;
	logic [7:0]  enable_one_r;
	logic [7:0]  enable_one_nxt;
	logic [7:0]  enable_two_r;
	logic [7:0]  enable_two_nxt;
	logic [7:0]  request_one_r;
	logic [7:0]  request_one_nxt;
	logic [7:0]  request_two_r;
	logic [7:0]  request_two_nxt;
	logic [7:0]  wakeup_flags_r;
	logic [7:0]  wakeup_flags_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	// exception sequencing
	intc_pkg::exc_state_e state_r;
	intc_pkg::exc_state_e state_nxt;
	logic        mask_r;
	logic        mask_nxt;
	logic        pending_r;
	logic        pending_nxt;
	logic        start_r;
	logic        start_nxt;
	logic [4:0]  vec_r;
	logic [4:0]  vec_nxt;
	logic [15:0] vaddr_r;
	logic [15:0] vaddr_nxt;

	// detected edges and set terms
	logic [4:0]  pin_edge;
	logic [7:0]  wake_edge;
	logic [7:0]  set_one;
	logic [7:0]  set_two;
	logic [20:0] eligible;
	logic [4:0]  winner;
	logic        any_eligible;

	// package counts must match the ports and the priority vector
	if ($bits(ext_request_pin) != intc_pkg::EXT_PINS)
		$error("ext_request_pin width differs from EXT_PINS");
	if ($bits(wakeup_pin) != intc_pkg::WAKE_PINS)
		$error("wakeup_pin width differs from WAKE_PINS");
	if ($bits(eligible) != intc_pkg::VEC_LAST + 1)
		$error("eligible width differs from VEC_LAST");

	// register port decode
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] target);
		hit = (a == target);
	endfunction

	// lowest vector number wins
	function automatic logic [4:0] pick(input logic [20:0] req);
		logic [4:0] v;
		v = '0;
		for (int i = intc_pkg::VEC_LAST; i >= 0; i--) begin
			if (req[i])
				v = 5'(i);
		end
		pick = v;
	endfunction

	// synchronised edge detection of request pins
	pin_edge_sync #(
		.WIDTH(intc_pkg::EXT_PINS)
	) u_ext_sync (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.pin       (ext_request_pin),
		.rise_sel  (edge_sel_r[4:0]),
		.edge_pulse(pin_edge)
	);

	// wakeup pins active low, falling edge
	pin_edge_sync #(
		.WIDTH(intc_pkg::WAKE_PINS)
	) u_wake_sync (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.pin       (wakeup_pin),
		.rise_sel  (8'h00),
		.edge_pulse(wake_edge)
	);

	// flag set terms
	always_comb begin
		set_one = '0;
		set_one[4:0] = pin_edge;
		set_one[intc_pkg::BIT_TIMER_A] = timer_a_ovf;
		set_one[intc_pkg::BIT_SERIAL1] = serial1_done;
		set_two = '0;
		set_two[intc_pkg::BIT_TIMER_B] = timer_b_ovf;
		set_two[intc_pkg::BIT_TIMER_C] = timer_c_ovf;
		set_two[intc_pkg::BIT_LOW_TM]  =
			low_timer_match | low_timer_ovf;
		set_two[intc_pkg::BIT_HIGH_TM] =
			high_timer_match | high_timer_ovf;
		set_two[intc_pkg::BIT_TIMER_G] =
			timer_g_capture | timer_g_ovf;
		set_two[intc_pkg::BIT_SERIAL2] =
			serial2_done | serial2_abort;
		set_two[intc_pkg::BIT_ADC]     = adc_done;
		set_two[intc_pkg::BIT_DIRECT]  = direct_transfer;
	end

	// register writes and flag updates
	always_comb begin
		edge_sel_nxt     = edge_sel_r;
		enable_one_nxt   = enable_one_r;
		enable_two_nxt   = enable_two_r;
		request_one_nxt  = request_one_r | set_one;
		request_two_nxt  = request_two_r | set_two;
		wakeup_flags_nxt = wakeup_flags_r | wake_edge;
		if (reg_wr) begin
			if (hit(reg_addr, intc_pkg::ADDR_EDGE_SEL))
				edge_sel_nxt = reg_wdata;
			if (hit(reg_addr, intc_pkg::ADDR_ENABLE_1))
				enable_one_nxt = reg_wdata;
			if (hit(reg_addr, intc_pkg::ADDR_ENABLE_2))
				enable_two_nxt = reg_wdata;
			// zero clears, one keeps, a new event wins
			if (hit(reg_addr, intc_pkg::ADDR_REQUEST_1))
				request_one_nxt =
					(request_one_r & reg_wdata) | set_one;
			if (hit(reg_addr, intc_pkg::ADDR_REQUEST_2))
				request_two_nxt =
					(request_two_r & reg_wdata) | set_two;
			if (hit(reg_addr, intc_pkg::ADDR_WAKEUP))
				wakeup_flags_nxt =
					(wakeup_flags_r & reg_wdata) | wake_edge;
		end
		edge_sel_nxt    = edge_sel_nxt | intc_pkg::EDGE_SEL_FIXED;
		request_one_nxt = request_one_nxt | intc_pkg::REQUEST_1_FIXED;
	end

	// read data, one cycle after the strobe
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			if (hit(reg_addr, intc_pkg::ADDR_EDGE_SEL))
				rdata_nxt = edge_sel_r;
			else if (hit(reg_addr, intc_pkg::ADDR_ENABLE_1))
				rdata_nxt = enable_one_r;
			else if (hit(reg_addr, intc_pkg::ADDR_ENABLE_2))
				rdata_nxt = enable_two_r;
			else if (hit(reg_addr, intc_pkg::ADDR_REQUEST_1))
				rdata_nxt = request_one_r;
			else if (hit(reg_addr, intc_pkg::ADDR_REQUEST_2))
				rdata_nxt = request_two_r;
			else if (hit(reg_addr, intc_pkg::ADDR_WAKEUP))
				rdata_nxt = wakeup_flags_r;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			edge_sel_r     <= intc_pkg::RST_EDGE_SEL;
			enable_one_r   <= intc_pkg::RST_ENABLE_1;
			enable_two_r   <= intc_pkg::RST_ENABLE_2;
			request_one_r  <= intc_pkg::RST_REQUEST_1;
			request_two_r  <= intc_pkg::RST_REQUEST_2;
			wakeup_flags_r <= intc_pkg::RST_WAKEUP;
			rdata_r        <= 8'h00;
		end else begin
			edge_sel_r     <= edge_sel_nxt;
			enable_one_r   <= enable_one_nxt;
			enable_two_r   <= enable_two_nxt;
			request_one_r  <= request_one_nxt;
			request_two_r  <= request_two_nxt;
			wakeup_flags_r <= wakeup_flags_nxt;
			rdata_r        <= rdata_nxt;
		end
	end

	// eligible sources indexed by vector number
	always_comb begin
		eligible = '0;
		for (int n = 0; n < intc_pkg::EXT_PINS; n++)
			eligible[int'(intc_pkg::VEC_PIN0) + n] =
				request_one_r[n] & enable_one_r[n];
		eligible[intc_pkg::VEC_WAKEUP] = (|wakeup_flags_r)
			& enable_one_r[intc_pkg::BIT_WAKEUP];
		eligible[intc_pkg::VEC_SERIAL1] =
			request_one_r[intc_pkg::BIT_SERIAL1]
			& enable_one_r[intc_pkg::BIT_SERIAL1];
		eligible[intc_pkg::VEC_TIMER_A] =
			request_one_r[intc_pkg::BIT_TIMER_A]
			& enable_one_r[intc_pkg::BIT_TIMER_A];
		eligible[intc_pkg::VEC_TIMER_B] =
			request_two_r[intc_pkg::BIT_TIMER_B]
			& enable_two_r[intc_pkg::BIT_TIMER_B];
		eligible[intc_pkg::VEC_TIMER_C] =
			request_two_r[intc_pkg::BIT_TIMER_C]
			& enable_two_r[intc_pkg::BIT_TIMER_C];
		eligible[intc_pkg::VEC_LOW_TM] =
			request_two_r[intc_pkg::BIT_LOW_TM]
			& enable_two_r[intc_pkg::BIT_LOW_TM];
		eligible[intc_pkg::VEC_HIGH_TM] =
			request_two_r[intc_pkg::BIT_HIGH_TM]
			& enable_two_r[intc_pkg::BIT_HIGH_TM];
		eligible[intc_pkg::VEC_TIMER_G] =
			request_two_r[intc_pkg::BIT_TIMER_G]
			& enable_two_r[intc_pkg::BIT_TIMER_G];
		eligible[intc_pkg::VEC_SERIAL2] =
			request_two_r[intc_pkg::BIT_SERIAL2]
			& enable_two_r[intc_pkg::BIT_SERIAL2];
		// serial3 enables and flags live in that unit
		eligible[intc_pkg::VEC_SERIAL3] = |serial3_req;
		eligible[intc_pkg::VEC_ADC] =
			request_two_r[intc_pkg::BIT_ADC]
			& enable_two_r[intc_pkg::BIT_ADC];
		eligible[intc_pkg::VEC_DIRECT] =
			request_two_r[intc_pkg::BIT_DIRECT]
			& enable_two_r[intc_pkg::BIT_DIRECT];
		if (mask_r)
			eligible = '0;
	end

	assign winner       = pick(eligible);
	assign any_eligible = |eligible;

	// exception sequencing
	always_comb begin
		state_nxt   = state_r;
		mask_nxt    = cpu_mask_bit;
		pending_nxt = any_eligible;
		start_nxt   = 1'b0;
		vec_nxt     = vec_r;
		vaddr_nxt   = vaddr_r;
		case (state_r)
			intc_pkg::ST_RESET: begin
				mask_nxt  = 1'b1;
				start_nxt = 1'b1;
				vec_nxt   = intc_pkg::VEC_RESET;
				vaddr_nxt = {10'h000, intc_pkg::VEC_RESET, 1'b0};
				state_nxt = intc_pkg::ST_HANDLE;
			end
			intc_pkg::ST_IDLE: begin
				if (instr_boundary && any_eligible) begin
					start_nxt = 1'b1;
					vec_nxt   = winner;
					vaddr_nxt = {10'h000, winner, 1'b0};
					state_nxt = intc_pkg::ST_HANDLE;
				end
			end
			intc_pkg::ST_HANDLE: begin
				// flags stay set; software clears them
				if (exc_done)
					state_nxt = intc_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = intc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r   <= intc_pkg::ST_RESET;
			mask_r    <= 1'b1;
			pending_r <= 1'b0;
			start_r   <= 1'b0;
			vec_r     <= intc_pkg::VEC_RESET;
			vaddr_r   <= 16'h0000;
		end else begin
			state_r   <= state_nxt;
			mask_r    <= mask_nxt;
			pending_r <= pending_nxt;
			start_r   <= start_nxt;
			vec_r     <= vec_nxt;
			vaddr_r   <= vaddr_nxt;
		end
	end

	assign reg_rdata   = rdata_r;
	assign int_pending = pending_r;
	assign exc_start   = start_r;
	assign vector_num  = vec_r;
	assign vector_addr = vaddr_r;
endmodule // prioritized_interrupt_controller

/* testbench/cpu_core_model.sv */
// cpu core stand-in: mask bit, instruction boundaries, handler length
// assumes the controller's accept pulse on the same clock
module cpu_core_model #(
	parameter int HOLD = 30
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic exc_start,
	input  wire logic mask_req,
	input  wire logic slow,
	output logic      cpu_mask_bit,
	output logic      instr_boundary,
	output logic      exc_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int         cnt;
	logic [1:0] tick;
	// masked in reset, on request and while handling
	assign cpu_mask_bit = !rstn || mask_req || cnt != 0;
	assign instr_boundary = slow ? tick == 2'h0 : 1'b1;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			tick <= 2'h0;
			exc_done <= 1'b0;
		end else begin
			tick <= tick + 2'h1;
			exc_done <= cnt == 1;
			if (exc_start)
				cnt <= HOLD;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule // cpu_core_model

/* testbench/intc_checker_sva.sv */
// checker of vector, mask and acceptance timing at the controller ports
// bound to the controller top; sees only its ports
module intc_checker (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        cpu_mask_bit,
	input wire logic        instr_boundary,
	input wire logic        exc_done,
	input wire logic        int_pending,
	input wire logic        exc_start,
	input wire logic [4:0]  vector_num,
	input wire logic [15:0] vector_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_r;
	logic busy_nxt;
	// handler in progress, from accept to its end
	always_comb begin
		busy_nxt = busy_r;
		if (exc_start)
			busy_nxt = 1'b1;
		else if (exc_done)
			busy_nxt = 1'b0;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			busy_r <= 1'b0;
		else
			busy_r <= busy_nxt;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	vec_addr_a: assert property (
		exc_start |-> vector_addr == {10'h000, vector_num, 1'b0})
		else $error("vector address not twice vector number");
	vec_range_a: assert property (
		exc_start |-> vector_num inside {5'h00, [5'h04:5'h14]})
		else $error("reserved or unknown vector issued");
	mask_block_a: assert property (
		cpu_mask_bit && $past(cpu_mask_bit) && $past(cpu_mask_bit, 2)
		|-> !int_pending) else $error("pending while masked");
	start_pulse_a: assert property (exc_start |=> !exc_start)
		else $error("accept pulse longer than one cycle");
	handle_block_a: assert property (exc_start |-> !$past(busy_r))
		else $error("accept during handling");
	boundary_a: assert property (
		exc_start && vector_num != 5'h00 |-> $past(instr_boundary))
		else $error("accept off an instruction boundary");
	eligible_a: assert property (
		exc_start && vector_num != 5'h00 |-> int_pending)
		else $error("accept without eligible source");
	reset_vec_a: assert property (
		$rose(rstn) |=> exc_start && vector_num == 5'h00)
		else $error("no reset vector after release");
	edge_read_a: assert property (
		reg_rd && reg_addr == 16'hFFF2 |=> reg_rdata[7:5] == 3'b111)
		else $error("edge select upper bits not one");
	cover property (exc_start && vector_num == 5'h04);
	cover property (exc_start && vector_num == 5'h09);
	cover property (exc_start && vector_num == 5'h14);
endmodule // intc_checker

bind prioritized_interrupt_controller intc_checker intc_checker_i (
	.core_clk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .cpu_mask_bit,
	.instr_boundary, .exc_done, .int_pending, .exc_start, .vector_num,
	.vector_addr);

/* testbench/prioritized_interrupt_controller_tb_top.sv */
// self-checking bench of the prioritized interrupt controller
// assumes checker and cpu core model compiled before it
module prioritized_interrupt_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [4:0]  ext_request_pin = 5'h1F;
	logic [7:0]  wakeup_pin = 8'hFF;
	logic [13:0] ev = 14'h0000;
	logic [5:0]  serial3_req = 6'h00;
	logic        mask_req = 1'b1;
	logic        slow = 1'b0;
	logic        cpu_mask_bit;
	logic        instr_boundary;
	logic        exc_done;
	logic        int_pending;
	logic        exc_start;
	logic [4:0]  vector_num;
	logic [15:0] vector_addr;
	logic [7:0]  b;
	int          miscompares = 0;
	int          tests_run = 0;
	int          i;
	logic [15:0] addr_t [7] = '{16'hFFF2, 16'hFFF3, 16'hFFF4, 16'hFFF6,
		16'hFFF7, 16'hFFF9, 16'hFFF5};
	logic [7:0]  rst_t [7] = '{8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00,
		8'h00};
	logic [4:0]  vexp [14] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0E,
		5'h0F, 5'h0F, 5'h10, 5'h10, 5'h11, 5'h11, 5'h13, 5'h14};

	always #20 core_clk = ~core_clk;

	prioritized_interrupt_controller prioritized_interrupt_controller_i (
		.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ext_request_pin, .wakeup_pin,
		.serial1_done(ev[0]), .timer_a_ovf(ev[1]), .timer_b_ovf(ev[2]),
		.timer_c_ovf(ev[3]), .low_timer_match(ev[4]),
		.low_timer_ovf(ev[5]), .high_timer_match(ev[6]),
		.high_timer_ovf(ev[7]), .timer_g_capture(ev[8]),
		.timer_g_ovf(ev[9]), .serial2_done(ev[10]),
		.serial2_abort(ev[11]), .serial3_req, .adc_done(ev[12]),
		.direct_transfer(ev[13]), .cpu_mask_bit, .instr_boundary,
		.exc_done, .int_pending, .exc_start, .vector_num, .vector_addr);

	cpu_core_model cpu_core_model_i (
		.core_clk, .rstn, .exc_start, .mask_req, .slow, .cpu_mask_bit,
		.instr_boundary, .exc_done);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, "read data");
	endtask
	task automatic pins(input logic [4:0] p, input logic [7:0] w,
		input int settle);
		@(posedge core_clk);
		ext_request_pin <= p;
		wakeup_pin <= w;
		repeat (settle) @(posedge core_clk);
	endtask
	task automatic expect_vec(input logic [4:0] v);
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			#1 k++;
		end while (exc_start !== 1'b1 && k < 60);
		chk(exc_start, 16'h0001, "accept pulse");
		chk(vector_num, v, "vector number");
		chk(vector_addr, {10'h000, v, 1'b0}, "vector address");
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		expect_vec(5'h00);
		for (i = 0; i < 7; i++)
			rd(addr_t[i], rst_t[i]);
		wr(16'hFFF2, 8'h00);
		rd(16'hFFF2, 8'hE0);
		wr(16'hFFF3, 8'hA5);
		wr(16'hFFF4, 8'h5A);
		rd(16'hFFF3, 8'hA5);
		rd(16'hFFF4, 8'h5A);
		for (i = 3; i < 6; i++) begin
			wr(addr_t[i], 8'hFF);
			rd(addr_t[i], rst_t[i]);
		end
		done("registers");
		for (i = 0; i < 5; i++) begin
			b = 8'h01 << i;
			pins(~b[4:0], 8'hFF, 5);
			rd(16'hFFF6, 8'h20 | b);
			wr(16'hFFF6, ~b);
			pins(5'h1F, 8'hFF, 5);
			rd(16'hFFF6, 8'h20);
			wr(16'hFFF2, b);
			pins(~b[4:0], 8'hFF, 5);
			rd(16'hFFF6, 8'h20);
			pins(5'h1F, 8'hFF, 5);
			rd(16'hFFF6, 8'h20 | b);
			wr(16'hFFF6, 8'h00);
			wr(16'hFFF2, 8'h00);
		end
		done("pin edges");
		wr(16'hFFF3, 8'hFF);
		wr(16'hFFF4, 8'hFF);
		pins(5'h00, 8'hFF, 5);
		#1 chk(int_pending, 16'h0000, "pending while masked");
		rd(16'hFFF6, 8'h3F);
		@(posedge core_clk);
		mask_req <= 1'b0;
		for (i = 0; i < 5; i++) begin
			expect_vec(5'h04 + i[4:0]);
			rd(16'hFFF6, 8'h20 | ((8'h1F << i) & 8'h1F));
			wr(16'hFFF6, ~(8'h01 << i));
		end
		pins(5'h1F, 8'hFF, 5);
		done("pin priority");
		for (i = 0; i < 8; i++) begin
			b = 8'h01 << i;
			pins(5'h1F, ~b, 0);
			expect_vec(5'h09);
			rd(16'hFFF9, b);
			wr(16'hFFF9, 8'h00);
			pins(5'h1F, 8'hFF, 0);
		end
		done("wakeup");
		@(posedge core_clk);
		slow <= 1'b1;
		for (i = 0; i < 15; i++) begin
			@(posedge core_clk);
			ev <= (i == 14) ? 14'h3FFF : 14'h0001 << i;
			@(posedge core_clk);
			ev <= 14'h0000;
			expect_vec((i == 14) ? 5'h0A : vexp[i]);
			wr(16'hFFF6, 8'h00);
			wr(16'hFFF7, 8'h00);
		end
		for (i = 0; i < 6; i++) begin
			@(posedge core_clk);
			serial3_req <= 6'h01 << i;
			expect_vec(5'h12);
			@(posedge core_clk);
			serial3_req <= 6'h00;
		end
		done("internal sources");
		wr(16'hFFF4, 8'h00);
		@(posedge core_clk);
		ev <= 14'h2000;
		@(posedge core_clk);
		ev <= 14'h0000;
		repeat (40) @(posedge core_clk);
		#1 chk(int_pending, 16'h0000, "pending while disabled");
		rd(16'hFFF7, 8'h80);
		done("disabled source");
		end_of_test();
	end
endmodule // prioritized_interrupt_controller_tb_top
